// file: inc/sbt_pkg.sv
// Package for the sixteen bit timer: register map, fields, constants and types
package sbt_pkg;

  // ==========================================================================
  // Register indices (byte registers on a plain port)
  localparam logic [11:0] ADDR_CONTROL   = 12'hfcd; // Timer control register
  localparam logic [11:0] ADDR_COUNT_LO  = 12'hfce; // Count low byte
  localparam logic [11:0] ADDR_COUNT_HI  = 12'hfcf; // Count high byte
  localparam logic [11:0] ADDR_STATUS    = 12'hfd0; // Sticky event status
  localparam logic [11:0] ADDR_MASK      = 12'hfd1; // Interrupt mask
  localparam logic [11:0] ADDR_GATE      = 12'hfd2; // Gate control / clock flag

  // ==========================================================================
  // Control fields
  localparam int CTL_SRC_HI    = 7; // Clock source field top
  localparam int CTL_SRC_LO    = 6; // Clock source field bottom
  localparam int CTL_PRE_HI    = 5; // Prescale field top
  localparam int CTL_PRE_LO    = 4; // Prescale field bottom
  localparam int CTL_OSC_EN    = 3; // Low-power oscillator enable
  localparam int CTL_SYNC_DIS  = 2; // External sync disable
  localparam int CTL_WIDE      = 1; // Wide access enable
  localparam int CTL_ON        = 0; // Count on
  localparam logic [7:0] CTL_RESET = 8'h00; // Control reset value

  // Status bit positions
  localparam int STS_OVF       = 0; // Overflow event
  localparam int STS_SPECIAL   = 1; // Special event clear seen
  // Gate register bit positions
  localparam int GATE_EN       = 0; // Gated mode enable
  localparam int GATE_POL      = 1; // Gate active level
  localparam int GATE_RUN_FLAG = 7; // Device clock from oscillator (read only)

  // Source encodings
  localparam logic [1:0] SRC_INSTR = 2'h0; // System clock divided by four
  localparam logic [1:0] SRC_SYS   = 2'h1; // System clock
  localparam logic [1:0] SRC_EXT   = 2'h2; // Oscillator or pin

  localparam logic [1:0] INSTR_DIV_LAST = 2'h3; // Last phase of divide by four
  localparam logic [7:0] BYTE_ZERO      = 8'h00; // Zero byte
  localparam logic [15:0] COUNT_ONES    = 16'hffff; // Rollover value

  // Control register as a struct
  typedef struct packed {
    logic [1:0] src;      // Clock source select
    logic [1:0] pre;      // Prescale select
    logic       osc_en;   // Low-power oscillator enable
    logic       sync_dis; // External sync disable
    logic       wide;     // Wide access enable
    logic       on;       // Count on
  } sbt_ctl_t;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;  // Byte address
    logic [7:0]  wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } sbt_bus_t;

endpackage

// file: verilog/sbt_prescale.sv
// Prescaler that divides tick pulses by 1, 2, 4 or 8
`timescale 1ns/1ps
module sbt_prescale
  import sbt_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       tick_in,
  input  wire logic [1:0] sel,
  output logic            tick_out
);

  // ==========================================================================
  // Divider
  logic [W-1:0] cnt_q; // Tick counter
  logic [W-1:0] lim;   // Last count for this ratio

  // Last count value is 2^sel - 1
  always_comb begin
    lim = W'((1 << sel) - 1);
  end

  // Pass a tick each time the counter wraps
  assign tick_out = tick_in && (cnt_q >= lim); // RQ4

  // Count incoming ticks, restart on clear
  always_ff @(posedge clk) begin
    if (rst || (ce && clr)) begin
      cnt_q <= '0;
    end else if (ce && tick_in) begin
      // A ratio change can leave the counter above the new limit; wrap at once
      cnt_q <= (cnt_q >= lim) ? '0 : W'(cnt_q + 1'b1); // RQ4
    end
  end

endmodule

// file: verilog/sbt_timer.sv
// Sixteen bit timer/counter with byte registers and overflow interrupt
//
// Functional notes
// RQ1: Sixteen bit count from internal or external clock.
// RQ2: Count readable and writable as two bytes.
// RQ3: Bits 7-6 choose clock source.
// RQ4: Bits 5-4 choose prescale 1,2,4,8.
// RQ5: Bit 3 enables low-power oscillator.
// RQ6: External clock synchronized unless bit 2 set.
// RQ7: Internal sources ignore the sync bit.
// RQ8: Bit 1 makes count access sixteen bit.
// RQ9: Count advances only while bit 0 set.
// RQ10: Special event trigger clears the count.
// RQ11: Gate input qualifies counting edges.
// RQ12: Software avoids system clock with capture/compare.
// RQ13: Flag shows device clock from oscillator.
// RQ14: Rollover sets sticky overflow flag.
`timescale 1ns/1ps
module sbt_timer
  import sbt_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire sbt_bus_t    bus,
  output logic [7:0]       rdata,
  input  wire logic        ext_clk_pin,
  input  wire logic        gate_in,
  input  wire logic        special_event,
  input  wire logic        dev_clk_from_osc,
  output logic             osc_enable,
  output logic             irq
);

  // ==========================================================================
  // Registers
  sbt_ctl_t        ctl_q;     // Control register
  logic [CW-1:0]   count_q;   // Running count
  logic [7:0]      hi_buf_q;  // Buffered high byte for wide access
  logic [1:0]      sts_q;     // Sticky status
  logic [1:0]      mask_q;    // Interrupt mask
  logic [1:0]      gate_q;    // Gate enable and polarity
  logic            ext_s1_q;  // Synchroniser first stage
  logic            ext_s2_q;  // Synchroniser second stage
  logic            ext_s3_q;  // Previous synchronised level
  logic            ext_raw_q; // Previous raw level
  logic [1:0]      div4_q;    // Divide by four phase

  // Decoded writes and reads
  function automatic logic hit(input sbt_bus_t b, input logic [11:0] a);
    return b.addr == a;
  endfunction

  logic wr_ctl, wr_lo, wr_hi, wr_sts, wr_mask, wr_gate, rd_lo;
  assign wr_ctl  = bus.wr && hit(bus, ADDR_CONTROL);
  assign wr_lo   = bus.wr && hit(bus, ADDR_COUNT_LO);
  assign wr_hi   = bus.wr && hit(bus, ADDR_COUNT_HI);
  assign wr_sts  = bus.wr && hit(bus, ADDR_STATUS);
  assign wr_mask = bus.wr && hit(bus, ADDR_MASK);
  assign wr_gate = bus.wr && hit(bus, ADDR_GATE);
  assign rd_lo   = bus.rd && hit(bus, ADDR_COUNT_LO);

  // ==========================================================================
  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_q <= sbt_ctl_t'(CTL_RESET);
    end else if (ce && wr_ctl) begin
      ctl_q <= sbt_ctl_t'(bus.wdata); // RQ3
    end
  end

  // Oscillator enable pin follows bit 3
  assign osc_enable = ctl_q.osc_en; // RQ5

  // ==========================================================================
  // Clock source selection
  // Synchroniser for external pin; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
      ext_s3_q  <= 1'b0;
      ext_raw_q <= 1'b0;
    end else if (ce) begin
      ext_s1_q  <= ext_clk_pin; // RQ6
      ext_s2_q  <= ext_s1_q;
      ext_s3_q  <= ext_s2_q;
      ext_raw_q <= ext_clk_pin;
    end
  end

  // Divide by four for the instruction clock
  always_ff @(posedge clk) begin
    if (rst) begin
      div4_q <= '0;
    end else if (ce) begin
      div4_q <= div4_q + 2'h1;
    end
  end

  logic ext_tick_sync; // Rising edge after synchronisation
  logic ext_tick_raw;  // Rising edge without synchronisation
  assign ext_tick_sync = ext_s2_q && !ext_s3_q;
  assign ext_tick_raw  = ext_clk_pin && !ext_raw_q;

  logic src_tick; // Selected source tick
  always_comb begin
    case (ctl_q.src)
      SRC_INSTR: src_tick = (div4_q == INSTR_DIV_LAST); // RQ7
      SRC_SYS:   src_tick = 1'b1; // RQ7
      SRC_EXT:   src_tick = ctl_q.sync_dis ? ext_tick_raw : ext_tick_sync; // RQ6
      default:   src_tick = 1'b0;
    endcase
  end

  // Gate qualifies the source
  logic gate_ok; // Counting allowed by gate
  assign gate_ok = !gate_q[GATE_EN] || (gate_in == gate_q[GATE_POL]); // RQ11

  logic pre_tick; // Tick after prescaler
  sbt_prescale #(
    .W (3)
  ) u_pre (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .clr      (wr_lo || wr_hi),
    .tick_in  (src_tick && gate_ok && ctl_q.on),
    .sel      (ctl_q.pre),
    .tick_out (pre_tick)
  );

  // ==========================================================================
  // Count register
  logic inc;      // Count advances this cycle
  logic rollover; // Count wraps this cycle
  assign inc      = pre_tick && ctl_q.on; // RQ9
  assign rollover = inc && (count_q == COUNT_ONES) && !special_event && !wr_lo && !(wr_hi && !ctl_q.wide); // RQ14

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (ce) begin
      if (special_event) begin
        count_q <= '0; // RQ10
      end else if (wr_lo) begin
        // Wide mode loads the buffered high byte together with the low byte
        count_q <= ctl_q.wide ? {hi_buf_q, bus.wdata} : {count_q[CW-1:8], bus.wdata}; // RQ8 RQ2
      end else if (wr_hi && !ctl_q.wide) begin
        count_q <= {bus.wdata, count_q[7:0]}; // RQ2
      end else if (inc) begin
        count_q <= CW'(count_q + 1'b1); // RQ1
      end
    end
  end

  // High byte buffer: latched on low read, loaded on high write in wide mode
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_buf_q <= BYTE_ZERO;
    end else if (ce) begin
      if (wr_hi && ctl_q.wide) begin
        hi_buf_q <= bus.wdata; // RQ8
      end else if (rd_lo && ctl_q.wide) begin
        hi_buf_q <= count_q[CW-1:8]; // RQ8
      end
    end
  end

  // ==========================================================================
  // Interrupt status, mask and gate
  always_ff @(posedge clk) begin
    if (rst) begin
      sts_q <= '0;
    end else if (ce) begin
      // Set wins over write-one-to-clear
      sts_q[STS_OVF]     <= rollover || (sts_q[STS_OVF] && !(wr_sts && bus.wdata[STS_OVF])); // RQ14
      sts_q[STS_SPECIAL] <= special_event || (sts_q[STS_SPECIAL] && !(wr_sts && bus.wdata[STS_SPECIAL]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= '0;
      gate_q <= '0;
    end else if (ce) begin
      if (wr_mask) begin
        mask_q <= bus.wdata[1:0];
      end
      if (wr_gate) begin
        gate_q <= {bus.wdata[GATE_POL], bus.wdata[GATE_EN]}; // RQ11
      end
    end
  end

  // Level interrupt
  assign irq = |(sts_q & mask_q);

  // ==========================================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= BYTE_ZERO;
    end else if (ce) begin
      if (bus.rd) begin
        case (bus.addr)
          ADDR_CONTROL:  rdata <= ctl_q;
          ADDR_COUNT_LO: rdata <= count_q[7:0]; // RQ2
          ADDR_COUNT_HI: rdata <= ctl_q.wide ? hi_buf_q : count_q[CW-1:8]; // RQ8
          ADDR_STATUS:   rdata <= {6'h00, sts_q};
          ADDR_MASK:     rdata <= {6'h00, mask_q};
          ADDR_GATE:     rdata <= {dev_clk_from_osc, 5'h00, gate_q}; // RQ13
          default:       rdata <= BYTE_ZERO;
        endcase
      end else begin
        rdata <= BYTE_ZERO;
      end
    end
  end

  // ==========================================================================
  // Assertions
  property p_onstop;
    @(posedge clk) disable iff (rst)
      (ce && !ctl_q.on && !special_event && !wr_lo && !wr_hi) |=> $stable(count_q);
  endproperty
  a_onstop: assert property (p_onstop) else $error("count moved while off"); // RQ9

  property p_clear;
    @(posedge clk) disable iff (rst)
      (ce && special_event) |=> (count_q == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("special event did not clear"); // RQ10

  property p_ovf;
    @(posedge clk) disable iff (rst)
      (ce && rollover) |=> (sts_q[STS_OVF] && count_q == '0);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // RQ14

  property p_inc;
    @(posedge clk) disable iff (rst)
      (ce && inc && !special_event && !wr_lo && !wr_hi) |=> (count_q == CW'($past(count_q) + 1'b1));
  endproperty
  a_inc: assert property (p_inc) else $error("count did not step"); // RQ1

  property p_sys;
    @(posedge clk) disable iff (rst)
      (ctl_q.src == SRC_SYS && ctl_q.on && ctl_q.pre == 2'h0 && gate_ok) |-> inc;
  endproperty
  a_sys: assert property (p_sys) else $error("system clock not counted"); // RQ3

  property p_gate;
    @(posedge clk) disable iff (rst)
      (gate_q[GATE_EN] && gate_in != gate_q[GATE_POL]) |-> !inc;
  endproperty
  a_gate: assert property (p_gate) else $error("gate ignored"); // RQ11

  property p_osc;
    @(posedge clk) disable iff (rst)
      (ce && wr_ctl) |=> (osc_enable == $past(bus.wdata[CTL_OSC_EN]));
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong"); // RQ5

  sequence s_wide_load;
    (ce && wr_hi && ctl_q.wide) ##[1:2] (ce && wr_lo && !special_event);
  endsequence
  property p_wide;
    @(posedge clk) disable iff (rst)
      s_wide_load |=> (count_q[CW-1:8] == $past(hi_buf_q));
  endproperty
  a_wide: assert property (p_wide) else $error("wide write lost high byte"); // RQ8

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !ce |=> ($stable(count_q) && $stable(ctl_q) && $stable(sts_q) && $stable(rdata));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_rd_idle;
    @(posedge clk) disable iff (rst)
      (ce && !bus.rd) |=> (rdata == BYTE_ZERO);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after idle cycle");

  property p_rd_low;
    @(posedge clk) disable iff (rst)
      (ce && bus.rd && bus.addr == ADDR_COUNT_LO) |=> (rdata == $past(count_q[7:0]));
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low byte read wrong"); // RQ2

  property p_narrow_hi;
    @(posedge clk) disable iff (rst)
      (ce && wr_hi && !ctl_q.wide && !special_event) |=> (count_q[CW-1:8] == $past(bus.wdata));
  endproperty
  a_narrow_hi: assert property (p_narrow_hi) else $error("high byte write lost"); // RQ2

  property p_wide_read;
    @(posedge clk) disable iff (rst)
      (ce && rd_lo && ctl_q.wide && !bus.wr) |=> (hi_buf_q == $past(count_q[CW-1:8]));
  endproperty
  a_wide_read: assert property (p_wide_read) else $error("low read did not latch high byte"); // RQ8

  property p_instr;
    @(posedge clk) disable iff (rst)
      (ce && ctl_q.src == SRC_INSTR && src_tick) |=> (!(ctl_q.src == SRC_INSTR && src_tick))[*3];
  endproperty
  a_instr: assert property (p_instr) else $error("instruction clock ticked too often"); // RQ7

  sequence s_sync_edge;
    (ce && ext_s1_q && !ext_s2_q) ##1 (ce && ctl_q.src == SRC_EXT && !ctl_q.sync_dis);
  endsequence
  property p_sync;
    @(posedge clk) disable iff (rst)
      s_sync_edge |-> src_tick;
  endproperty
  a_sync: assert property (p_sync) else $error("synchronised pin edge not counted"); // RQ6

  property p_raw;
    @(posedge clk) disable iff (rst)
      (ce && ctl_q.src == SRC_EXT && ctl_q.sync_dis && src_tick)
        |=> !(ctl_q.src == SRC_EXT && ctl_q.sync_dis && src_tick);
  endproperty
  a_raw: assert property (p_raw) else $error("raw pin edge counted twice"); // RQ6

  property p_irq;
    @(posedge clk) disable iff (rst)
      (ce && rollover && mask_q[STS_OVF] && !wr_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked overflow did not interrupt"); // RQ14

  property p_w1c;
    @(posedge clk) disable iff (rst)
      (ce && wr_sts && bus.wdata[STS_OVF] && !rollover) |=> !sts_q[STS_OVF];
  endproperty
  a_w1c: assert property (p_w1c) else $error("overflow flag not cleared"); // RQ14

  property p_sticky;
    @(posedge clk) disable iff (rst)
      (ce && sts_q[STS_OVF] && !(wr_sts && bus.wdata[STS_OVF])) |=> sts_q[STS_OVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped"); // RQ14

  property p_special_flag;
    @(posedge clk) disable iff (rst)
      (ce && special_event) |=> sts_q[STS_SPECIAL];
  endproperty
  a_special_flag: assert property (p_special_flag) else $error("special event flag not set"); // RQ10

  property p_gate_flag;
    @(posedge clk) disable iff (rst)
      (ce && bus.rd && bus.addr == ADDR_GATE) |=> (rdata[GATE_RUN_FLAG] == $past(dev_clk_from_osc));
  endproperty
  a_gate_flag: assert property (p_gate_flag) else $error("clock source flag read wrong"); // RQ13

endmodule

// file: verification/sbt_ext_osc.sv
// External clock source model that drives the timer's clock pin in bursts
`timescale 1ns/1ps
module sbt_ext_osc #(
  parameter int HALF_NS = 25 // Half period of the pin clock; the pin rises 1 ns after clk falling edges and falls 1 ns after clk rising edges
) (
  input  wire logic       fire,
  input  wire logic [7:0] pulses,
  output logic            pin,
  output logic            busy
);
  // ==========================================================================
  // Burst generator
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end

  // Each rising edge of fire while busy is low sends one whole burst; the pin rests low between
  always @(posedge fire) begin
    busy = 1'b1;
    repeat (pulses) begin
      #HALF_NS pin = 1'b1;
      #HALF_NS pin = 1'b0;
    end
    busy = 1'b0;
  end
endmodule

// file: verification/sixteen_bit_timer_counter_tb.sv
// Self-checking bench for the sixteen bit timer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module sixteen_bit_timer_counter_tb import sbt_pkg::*;;
  logic       clk;           // Bench clock
  logic       rst;           // Synchronous reset
  logic       ce;            // Clock enable
  sbt_bus_t   bus;           // Register bus request
  logic [7:0] rdata;         // Read data
  logic       ext_pin;       // External clock pin
  logic       gate_in;       // Gate level
  logic       special_event; // Compare trigger
  logic       dev_clk_osc;   // Device clock from oscillator
  logic       osc_enable;    // Oscillator enable output
  logic       irq;           // Interrupt output
  logic       fire;          // Start a pin burst
  logic [7:0] pulses;        // Burst length
  logic       busy;          // Burst running
  int         failures;      // Mismatch count
  int         checks_done;   // Comparison count

  sbt_timer #(.CW(16)) DUT (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .ext_clk_pin(ext_pin), .gate_in(gate_in), .special_event(special_event),
    .dev_clk_from_osc(dev_clk_osc), .osc_enable(osc_enable), .irq(irq));
  sbt_ext_osc #(.HALF_NS(25)) osc (.fire(fire), .pulses(pulses), .pin(ext_pin), .busy(busy));

  // ==========================================================================
  // Bus tasks: one-cycle strobes, read data taken in the cycle after
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  // Count advance over exactly 32 clocks between two low-byte reads
  task automatic span(output logic [7:0] diff);
    logic [7:0] a;
    logic [7:0] b;
    rd(ADDR_COUNT_LO, a);
    repeat (30) @(posedge clk);
    rd(ADDR_COUNT_LO, b);
    diff = b - a;
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    `CHK("osc_enable", 1'b0, osc_enable)
    `CHK("irq", 1'b0, irq)
    wr(12'hfd3, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rd(ADDR_CONTROL + 12'(i), d);
      `CHK("reset value", 8'h00, d)
    end
    $display("test reset done");
  endtask

  task automatic t_rates();
    logic [7:0] d;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(ADDR_CONTROL, {2'(s), 2'(p), 4'h5});
        wr(ADDR_COUNT_LO, 8'h00);
        span(d);
        `CHK("rate", 8'(32 >> (p + (s == 0 ? 2 : 0))), d)
      end
    end
    wr(ADDR_CONTROL, 8'h40);
    span(d);
    `CHK("stopped", 8'h00, d)
    $display("test rates done");
  endtask

  task automatic t_ext();
    logic [7:0] a;
    logic [7:0] b;
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CONTROL, {4'h8, 1'b1, 1'(s), 2'h1});
      #1;
      `CHK("osc_enable", 1'b1, osc_enable)
      rd(ADDR_COUNT_LO, a);
      pulses <= 8'h0a;
      fire <= 1'b1;
      repeat (2) @(posedge clk);
      fire <= 1'b0;
      for (n = 0; n < 200 && busy; n++) @(posedge clk);
      if (n == 200) begin
        failures++;
        end_sim();
      end
      repeat (6) @(posedge clk);
      rd(ADDR_COUNT_LO, b);
      `CHK("pin edges", 8'h0a, 8'(b - a))
    end
    wr(ADDR_CONTROL, 8'h00);
    #1;
    `CHK("osc_enable", 1'b0, osc_enable)
    $display("test external done");
  endtask

  task automatic t_gate();
    logic [7:0] d;
    wr(ADDR_GATE, 8'h03);
    gate_in <= 1'b0;
    wr(ADDR_CONTROL, 8'h41);
    wr(ADDR_COUNT_LO, 8'h00);
    span(d);
    `CHK("gated off", 8'h00, d)
    gate_in <= 1'b1;
    span(d);
    `CHK("gated on", 8'h20, d)
    dev_clk_osc <= 1'b1;
    rd(ADDR_GATE, d);
    `CHK("osc clock flag", 1'b1, d[GATE_RUN_FLAG])
    wr(ADDR_GATE, 8'h00);
    $display("test gate done");
  endtask

  task automatic t_access();
    logic [7:0] d;
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_COUNT_HI, 8'hab);
    wr(ADDR_COUNT_LO, 8'hcd);
    wr(ADDR_COUNT_HI, 8'h55);
    rd(ADDR_COUNT_LO, d);
    `CHK("wide low", 8'hcd, d)
    rd(ADDR_COUNT_HI, d);
    `CHK("wide high", 8'hab, d)
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LO, 8'h12);
    wr(ADDR_COUNT_HI, 8'h34);
    rd(ADDR_COUNT_HI, d);
    `CHK("narrow high", 8'h34, d)
    rd(ADDR_COUNT_LO, d);
    `CHK("narrow low", 8'h12, d)
    $display("test access done");
  endtask

  task automatic t_events();
    logic [7:0] d;
    wr(ADDR_COUNT_LO, 8'hff);
    wr(ADDR_COUNT_HI, 8'hff);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_CONTROL, 8'h41);
    repeat (3) @(posedge clk);
    wr(ADDR_CONTROL, 8'h40);
    rd(ADDR_STATUS, d);
    `CHK("overflow flag", 8'h01, d)
    `CHK("irq raised", 1'b1, irq)
    wr(ADDR_MASK, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(ADDR_COUNT_HI, 8'h12);
    wr(ADDR_CONTROL, 8'h01);
    @(posedge clk);
    special_event <= 1'b1;
    @(posedge clk);
    special_event <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_HI, d);
    `CHK("cleared high", 8'h00, d)
    rd(ADDR_COUNT_LO, d);
    `CHK("cleared low small", 1'b1, d < 8'h08)
    rd(ADDR_STATUS, d);
    `CHK("special flag", 8'h02, d)
    $display("test events done");
  endtask

  // Clock enable low freezes the count; a mid-run reset clears the registers
  task automatic t_ce();
    logic [7:0] a;
    logic [7:0] b;
    wr(ADDR_CONTROL, 8'h41);
    rd(ADDR_COUNT_LO, a);
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    rd(ADDR_COUNT_LO, b);
    `CHK("frozen count", 8'h03, 8'(b - a))
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CONTROL, a);
    `CHK("reset control", 8'h00, a)
    rd(ADDR_STATUS, b);
    `CHK("reset status", 8'h00, b)
    $display("test enable and reset done");
  endtask

  // ==========================================================================
  // Clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bus = '0;
    gate_in = 1'b0;
    special_event = 1'b0;
    dev_clk_osc = 1'b0;
    fire = 1'b0;
    pulses = 8'h00;
    failures = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rates();
    t_ext();
    t_gate();
    t_access();
    t_events();
    t_ce();
    end_sim();
  end
endmodule
